//--- verilog/rpu_params.svh
`ifndef RPU_PARAMS_SVH
`define RPU_PARAMS_SVH

// ==========================================================
// register byte addresses
`define RPU_OFF_CTRL    8'h00
`define RPU_OFF_ICACHE  8'h04
`define RPU_OFF_DCACHE  8'h08
`define RPU_OFF_DBUF    8'h0C
`define RPU_OFF_DPERM   8'h10
`define RPU_OFF_IPERM   8'h14
`define RPU_OFF_STATUS  8'h18
`define RPU_OFF_REGION0 8'h20
`define RPU_OFF_REGION7 8'h3C

// ==========================================================
// field positions
`define RPU_CTRL_EN_BIT 0
`define RPU_BASE_MSB    31
`define RPU_BASE_LSB    12
`define RPU_SIZE_MSB    5
`define RPU_SIZE_LSB    1
`define RPU_EN_BIT      0
`define RPU_REGION_MASK 32'hFFFFF03F

// ==========================================================
// reset values and codes
`define RPU_RST_WORD    32'h00000000
`define RPU_RST_BYTE    8'h00
`define RPU_SIZE_4K     5'h0B
`define RPU_SIZE_4G     5'h1F
`define RPU_AP_PRIV     4'h1
`define RPU_AP_USER_RO  4'h2
`define RPU_AP_FULL     4'h3
`define RPU_AP_PRIV_RO  4'h5
`define RPU_AP_ALL_RO   4'h6

`endif

//--- verilog/rpu_pkg.sv
package rpu_pkg;

    // ==========================================================
    // one protection region
    typedef struct packed {
        logic [19:0] base;
        logic [4:0] size;
        logic en;
    } region_t;

    // one access issued by the core
    typedef struct packed {
        logic [31:0] addr;
        logic write;
        logic priv;
    } access_t;

    // outcome of one check
    typedef struct packed {
        logic abort;
        logic cachable;
        logic bufferable;
    } result_t;

endpackage

//--- verilog/region_match.sv
`include "rpu_params.svh"

module region_match
    import rpu_pkg::*;
(
    input wire region_t region, // region setup
    input wire logic [31:0] addr, // address under test
    output logic hit // address lies in region
);

    logic [19:0] bit_ok;

    // ==========================================================
    // compare only bits above the region size
    genvar b;
    generate
        for (b = 0; b < 20; b = b + 1)
        begin : g_bit
            assign bit_ok[b] =
                (5'(b + `RPU_BASE_LSB) <= region.size) ||
                (addr[b + `RPU_BASE_LSB] == region.base[b]);
        end
    endgenerate

    // enabled and all upper bits equal
    assign hit = region.en && (&bit_ok);

endmodule

//--- verilog/region_protection_unit.sv
// Behaviour
// - size code 0B is 4KB, each step doubles, 1F covers all 4GB.
// - each region holds cachable, bufferable and permission attributes.
// - failed fetch gives prefetch abort, failed data access data abort.
// - cachable and bufferable bits form a two-bit handling selection.
// - among matching regions the highest number wins.
// - eight independent regions, free to overlap.
// - an address in no enabled region is aborted while checking is on.
// - region 0 over 4GB acts as background for the rest.
// - code 1 privileged only; code 2 user read-only, user write aborts.
// - region word: base 31:12, size 5:1, enable 0 reset low.
// - checking runs only while control bit 0 is set.
// - checking off: fetches noncachable, data noncachable and unbuffered.
//
// The implementer's own choices: the address map and the Avalon-MM register port.
`include "rpu_params.svh"

module region_protection_unit
    import rpu_pkg::*;
(
    input wire logic CLK, // core clock
    input wire logic RST, // async reset, high
    input wire logic [7:0] AVS_ADDRESS, // byte address
    input wire logic AVS_READ, // read strobe
    input wire logic AVS_WRITE, // write strobe
    input wire logic [31:0] AVS_WRITEDATA, // write data
    input wire logic [3:0] AVS_BYTEENABLE, // byte lanes
    output logic [31:0] AVS_READDATA, // read data
    output logic AVS_WAITREQUEST, // stall
    input wire logic I_REQ, // fetch check request
    input wire access_t I_ACC, // fetch address
    output logic I_VALID, // fetch result valid
    output result_t I_RES, // fetch result
    input wire logic D_REQ, // data check request
    input wire access_t D_ACC, // data access
    output logic D_VALID, // data result valid
    output result_t D_RES // data result
);

    logic bus_wait, wr_go, ctrl_en, i_any, d_any;
    logic [31:0] rdata, next_rdata, dperm, iperm;
    logic [7:0] wa, icache, dcache, dbuf, i_hit, d_hit;
    logic [31:0] rword [8];
    region_t rg [8];
    logic [2:0] i_idx, d_idx;
    logic [1:0] d_sel;
    result_t next_ires, next_dres;
    logic [15:0] status;

    // ==========================================================
    // byte-lane merge
    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] wd, input logic [3:0] be);
        logic [31:0] m;
        m = old;
        for (int k = 0; k < 4; k++)
        begin
            if (be[k])
                m[k*8 +: 8] = wd[k*8 +: 8];
        end
        return m;
    endfunction
    // highest matching region
    function automatic logic [3:0] pick(input logic [7:0] h);
        logic [3:0] r;
        r = 4'h0;
        for (int k = 0; k < 8; k++)
        begin
            if (h[k])
                r = {1'b1, 3'(k)};
        end
        return r;
    endfunction
    // permission decode
    function automatic logic perm_ok(input logic [3:0] ap,
        input logic priv, input logic wr);
        case (ap)
            `RPU_AP_PRIV: perm_ok = priv;
            `RPU_AP_USER_RO: perm_ok = priv || !wr;
            `RPU_AP_FULL: perm_ok = 1'b1;
            `RPU_AP_PRIV_RO: perm_ok = priv && !wr;
            `RPU_AP_ALL_RO: perm_ok = !wr;
            default: perm_ok = 1'b0;
        endcase
    endfunction
    // ==========================================================
    // avalon slave: one wait cycle, then completion
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            bus_wait <= 1'b1;
        else
            bus_wait <= !((AVS_READ || AVS_WRITE) && bus_wait);
    end
    assign wr_go = AVS_WRITE && !bus_wait;
    assign wa = {AVS_ADDRESS[7:2], 2'b00};
    assign AVS_WAITREQUEST = bus_wait;
    assign AVS_READDATA = rdata;
    // control register
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            ctrl_en <= 1'b0;
        else if (wr_go && wa == `RPU_OFF_CTRL && AVS_BYTEENABLE[0])
            ctrl_en <= AVS_WRITEDATA[`RPU_CTRL_EN_BIT];
    end
    // attribute registers
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            icache <= `RPU_RST_BYTE;
            dcache <= `RPU_RST_BYTE;
            dbuf <= `RPU_RST_BYTE;
            dperm <= `RPU_RST_WORD;
            iperm <= `RPU_RST_WORD;
        end
        else if (wr_go)
        begin
            // low byte only carries the eight flags
            if (wa == `RPU_OFF_ICACHE && AVS_BYTEENABLE[0])
                icache <= AVS_WRITEDATA[7:0];
            if (wa == `RPU_OFF_DCACHE && AVS_BYTEENABLE[0])
                dcache <= AVS_WRITEDATA[7:0];
            if (wa == `RPU_OFF_DBUF && AVS_BYTEENABLE[0])
                dbuf <= AVS_WRITEDATA[7:0];
            if (wa == `RPU_OFF_DPERM)
                dperm <= merge(dperm, AVS_WRITEDATA, AVS_BYTEENABLE);
            if (wa == `RPU_OFF_IPERM)
                iperm <= merge(iperm, AVS_WRITEDATA, AVS_BYTEENABLE);
        end
    end

    // ==========================================================
    // eight regions and their matchers
    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1)
        begin : g_reg
            always_ff @(posedge CLK or posedge RST)
            begin
                if (RST)
                    rword[i] <= `RPU_RST_WORD;
                else if (wr_go && wa == 8'(`RPU_OFF_REGION0 + 4 * i))
                    rword[i] <= merge(rword[i], AVS_WRITEDATA,
                        AVS_BYTEENABLE) & `RPU_REGION_MASK;
            end
            assign rg[i] = '{base: rword[i][`RPU_BASE_MSB:`RPU_BASE_LSB],
                size: rword[i][`RPU_SIZE_MSB:`RPU_SIZE_LSB],
                en: rword[i][`RPU_EN_BIT]};
            region_match u_imatch (
                .region(rg[i]),
                .addr(I_ACC.addr),
                .hit(i_hit[i])
            );
            region_match u_dmatch (
                .region(rg[i]),
                .addr(D_ACC.addr),
                .hit(d_hit[i])
            );
        end
    endgenerate

    assign {i_any, i_idx} = pick(i_hit);
    assign {d_any, d_idx} = pick(d_hit);
    assign d_sel = {dcache[d_idx], dbuf[d_idx]};
    // read mux, unmapped reads as zero
    always_comb
    begin
        next_rdata = `RPU_RST_WORD;
        case (wa)
            `RPU_OFF_CTRL: next_rdata = {31'h0, ctrl_en};
            `RPU_OFF_ICACHE: next_rdata = {24'h0, icache};
            `RPU_OFF_DCACHE: next_rdata = {24'h0, dcache};
            `RPU_OFF_DBUF: next_rdata = {24'h0, dbuf};
            `RPU_OFF_DPERM: next_rdata = dperm;
            `RPU_OFF_IPERM: next_rdata = iperm;
            `RPU_OFF_STATUS: next_rdata = {16'h0, status};
            default:
            begin
                if (wa >= `RPU_OFF_REGION0 && wa <= `RPU_OFF_REGION7)
                    next_rdata = rword[wa[4:2]];
            end
        endcase
    end
    // read data loaded during the wait cycle
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            rdata <= `RPU_RST_WORD;
        else if (AVS_READ && bus_wait)
            rdata <= next_rdata;
    end
    // ==========================================================
    // check outcome for both ports
    always_comb
    begin
        next_ires = '{abort: 1'b0, cachable: 1'b0, bufferable: 1'b0};
        next_dres = '{abort: 1'b0, cachable: 1'b0, bufferable: 1'b0};
        if (ctrl_en)
        begin
            next_ires.abort = !i_any ||
                !perm_ok(iperm[{i_idx, 2'b00} +: 4], I_ACC.priv,
                1'b0);
            next_ires.cachable = i_any && icache[i_idx];
            next_dres.abort = !d_any ||
                !perm_ok(dperm[{d_idx, 2'b00} +: 4], D_ACC.priv,
                D_ACC.write);
            next_dres.cachable = d_any && dcache[d_idx];
            next_dres.bufferable = d_any && dbuf[d_idx];
        end
    end

    // result flops; a check made while checking is off gives an all-zero result
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            I_VALID <= 1'b0;
            D_VALID <= 1'b0;
            I_RES <= '{abort: 1'b0, cachable: 1'b0, bufferable: 1'b0};
            D_RES <= '{abort: 1'b0, cachable: 1'b0, bufferable: 1'b0};
        end
        else
        begin
            I_VALID <= I_REQ;
            D_VALID <= D_REQ;
            if (I_REQ)
                I_RES <= next_ires;
            if (D_REQ)
                D_RES <= next_dres;
        end
    end

    // status of latest checks
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            status <= 16'h0000;
        else
        begin
            if (I_REQ)
                status[7:0] <= {i_idx, i_any, 3'h0, next_ires.abort};
            if (D_REQ)
                status[15:8] <= {d_idx, d_any, 3'h0, next_dres.abort};
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    a_off_no_attr: assert property (
        D_REQ && !ctrl_en |=> D_VALID && D_RES == 3'b000)
        else $error("attributes set while protection off");
    a_miss_aborts: assert property (
        D_REQ && ctrl_en && d_hit == 8'h00 |=> D_RES.abort)
        else $error("access outside all regions not aborted");
    a_fetch_abort: assert property (
        I_REQ && ctrl_en && i_hit == 8'h00 |=> I_VALID && I_RES.abort)
        else $error("fetch outside regions no prefetch abort");
    a_top_priority: assert property (
        d_hit[7] |-> d_any && d_idx == 3'h7)
        else $error("region 7 did not win");
    a_background: assert property (
        rg[0].en && rg[0].size == `RPU_SIZE_4G && d_hit[7:1] == 7'h00
        |-> d_any && d_idx == 3'h0)
        else $error("background region not applied");
    a_user_ro_write: assert property (
        D_REQ && ctrl_en && d_any && !D_ACC.priv && D_ACC.write &&
        dperm[{d_idx, 2'b00} +: 4] == `RPU_AP_USER_RO |=> D_RES.abort)
        else $error("user write to read-only region passed");
    a_priv_only: assert property (
        D_REQ && ctrl_en && d_any && D_ACC.priv &&
        dperm[{d_idx, 2'b00} +: 4] == `RPU_AP_PRIV |=> !D_RES.abort)
        else $error("privileged access to privileged region aborted");
    a_size_4k: assert property (
        rg[2].en && rg[2].size == `RPU_SIZE_4K &&
        D_ACC.addr[31:12] == rg[2].base |-> d_hit[2])
        else $error("4KB region did not match its own page");
    a_cb_select: assert property (
        D_REQ && ctrl_en && d_any |=> {D_RES.cachable, D_RES.bufferable}
        == $past(d_sel))
        else $error("wrong cache and buffer selection");
    a_bus_answer: assert property (
        (AVS_READ || AVS_WRITE) && bus_wait |=> !bus_wait ##1 bus_wait)
        else $error("bus answer not one wait cycle");

    c_overlap: cover property (D_REQ && ctrl_en && $countones(d_hit) > 1);
    c_data_abort: cover property (D_VALID && D_RES.abort);
    c_fetch_ok: cover property (I_VALID && !I_RES.abort && I_RES.cachable);
    c_reg_write: cover property (wr_go && wa == `RPU_OFF_REGION0);

endmodule

//--- sim/core_model.sv
// ==========================================================
// core side: issues fetch and data checks
module core_model
    import rpu_pkg::*;
(
    input wire logic clk, // core clock
    output logic i_req, // fetch check request
    output access_t i_acc, // fetch access
    input wire logic i_valid, // fetch result valid
    input wire result_t i_res, // fetch result
    output logic d_req, // data check request
    output access_t d_acc, // data access
    input wire logic d_valid, // data result valid
    input wire result_t d_res // data result
);
    timeunit 1ns;
    timeprecision 1ns;

    // idle at time zero
    initial
    begin
        i_req = 1'b0;
        d_req = 1'b0;
        i_acc = '0;
        d_acc = '0;
    end

    // one check: request, then result one cycle later
    task automatic issue(input logic d, input access_t a,
                         output logic v, output result_t r);
        begin
            @(posedge clk);
            if (d)
                d_req <= 1'b1;
            else
                i_req <= 1'b1;
            i_acc <= a;
            d_acc <= a;
            @(posedge clk);
            i_req <= 1'b0;
            d_req <= 1'b0;
            i_acc <= ~a; // released lines do not keep the value
            d_acc <= ~a;
            @(posedge clk);
            v = d ? d_valid : i_valid;
            r = d ? d_res : i_res;
        end
    endtask
endmodule

//--- sim/test_region_protection_unit.sv
`include "rpu_params.svh"

module test_region_protection_unit
    import rpu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic i_req, i_valid, d_req, d_valid;
    access_t i_acc, d_acc;
    result_t i_res, d_res;
    int num_errors = 0;
    int cmp_count = 0;
    logic [31:0] rd;

    // ==========================================================
    // clock and design
    always #20 clk = ~clk;

    region_protection_unit uut (.CLK(clk), .RST(rst),
        .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
        .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
        .AVS_BYTEENABLE(4'hF), .AVS_READDATA(avs_readdata),
        .AVS_WAITREQUEST(avs_waitrequest), .I_REQ(i_req), .I_ACC(i_acc),
        .I_VALID(i_valid), .I_RES(i_res), .D_REQ(d_req), .D_ACC(d_acc),
        .D_VALID(d_valid), .D_RES(d_res));

    core_model cm (.clk(clk), .i_req(i_req), .i_acc(i_acc),
        .i_valid(i_valid), .i_res(i_res), .d_req(d_req), .d_acc(d_acc),
        .d_valid(d_valid), .d_res(d_res));

    // ==========================================================
    // shared tasks
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        begin
            cmp_count++;
            if (got !== exp)
            begin
                num_errors++;
                $display("unexpected %s: expected %h, seen %h", what, exp,
                         got);
            end
        end
    endtask

    // one avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] q);
        begin
            @(posedge clk);
            avs_address <= a;
            avs_writedata <= wd;
            avs_write <= wr;
            avs_read <= ~wr;
            @(posedge clk);
            // only the watchdog ends a wait that never completes
            while (avs_waitrequest !== 1'b0)
                @(posedge clk);
            q = avs_readdata;
            avs_write <= 1'b0;
            avs_read <= 1'b0;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        logic [31:0] q;
        begin
            bus(1'b1, a, wd, q);
        end
    endtask

    // one check through the core model, with expected {abort,cach,buf}
    task automatic acc(input logic d, input logic [31:0] a, input logic w,
                       input logic pv, input logic [2:0] exp);
        logic v;
        result_t r;
        begin
            cm.issue(d, '{addr: a, write: w, priv: pv}, v, r);
            chk(d ? "data check" : "fetch check", {1'b1, exp}, {v, r});
        end
    endtask

    // ==========================================================
    // scenarios
    task automatic t_reset;
        begin
            bus(1'b0, `RPU_OFF_REGION0, 0, rd);
            chk("region0", 0, rd);
            bus(1'b0, `RPU_OFF_REGION7, 0, rd);
            chk("region7", 0, rd);
            bus(1'b0, `RPU_OFF_CTRL, 0, rd);
            chk("ctrl", 0, rd);
            wr(`RPU_OFF_REGION0, 32'hFFFFFFFE);
            bus(1'b0, `RPU_OFF_REGION0, 0, rd);
            chk("region0 mask", 32'hFFFFF03E, rd);
            bus(1'b0, 8'h40, 0, rd);
            chk("unmapped", 0, rd);
            $display("test reset done");
        end
    endtask

    task automatic t_background;
        begin
            wr(`RPU_OFF_REGION0, 32'h0000003F);
            wr(`RPU_OFF_DPERM, 32'h00000003);
            wr(`RPU_OFF_IPERM, 32'h00000003);
            wr(`RPU_OFF_DCACHE, 32'h00000001);
            wr(`RPU_OFF_DBUF, 32'h00000001);
            wr(`RPU_OFF_ICACHE, 32'h00000001);
            acc(1'b1, 32'h80000000, 1'b1, 1'b0, 3'h0);
            acc(1'b0, 32'h80000000, 1'b0, 1'b0, 3'h0);
            wr(`RPU_OFF_CTRL, 32'h00000001);
            acc(1'b1, 32'h80000000, 1'b1, 1'b0, 3'h3);
            acc(1'b0, 32'hFFFFFFFC, 1'b0, 1'b0, 3'h2);
            wr(`RPU_OFF_REGION0, 32'h00000000);
            acc(1'b1, 32'h80000000, 1'b0, 1'b1, 3'h4);
            acc(1'b0, 32'h00000000, 1'b0, 1'b1, 3'h4);
            $display("test background done");
        end
    endtask

    task automatic t_overlap;
        logic [31:0] ad [10];
        logic [3:0] cd [10];
        begin
            // {write, priv, expected abort} per address
            ad = '{32'h3010, 32'h3010, 32'h3010, 32'h1000, 32'h1000,
                   32'h3FFC, 32'h2FFC, 32'h4000, 32'hFFFFFFFC, 32'h7FFFFFFC};
            cd = '{4'h5, 4'h0, 4'h6, 4'h1, 4'h2, 4'h0, 4'h1, 4'h3, 4'h4,
                   4'h1};
            wr(`RPU_OFF_DCACHE, 32'h00000000);
            wr(`RPU_OFF_DBUF, 32'h00000000);
            wr(`RPU_OFF_REGION0 + 8'h04, 32'h0000001B);
            wr(`RPU_OFF_REGION0 + 8'h08, 32'h00003017);
            wr(`RPU_OFF_REGION7, 32'h8000003D);
            wr(`RPU_OFF_DPERM, 32'h30000210);
            wr(`RPU_OFF_IPERM, 32'h30000210);
            for (int k = 0; k < 10; k++)
                acc(1'b1, ad[k], cd[k][2], cd[k][1],
                    {cd[k][0], 2'b00});
            acc(1'b0, 32'h3010, 1'b0, 1'b0, 3'h0);
            acc(1'b0, 32'h1000, 1'b0, 1'b0, 3'h4);
            // last fetch: region 1, hit, abort; last data: miss, abort
            bus(1'b0, `RPU_OFF_STATUS, 32'h00000000, rd);
            chk("status", 32'h00000131, rd);
            $display("test overlap done");
        end
    endtask

    // ==========================================================
    // verdict
    task automatic give_verdict;
        begin
            $display("checks %0d, mismatches %0d", cmp_count, num_errors);
            if (num_errors == 0 && cmp_count > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask

    // watchdog over the whole run
    initial
    begin
        repeat (5000) @(posedge clk);
        num_errors++;
        give_verdict();
    end

    // main sequence
    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_background();
        t_overlap();
        give_verdict();
    end
endmodule
